// File: include/tpg_params.svh
// register map, reset values and field layout of the three-port gpio block
// assumes an 8-bit register bus with a 16-bit byte address
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH

// register offsets
`define TPG_ADDR_W 16
`define TPG_OFS_A_DRIVE 16'h7f96
`define TPG_OFS_B_DRIVE 16'h7f97
`define TPG_OFS_C_DRIVE 16'h7f98
`define TPG_OFS_A_LEVEL 16'h7f99
`define TPG_OFS_B_LEVEL 16'h7f9a
`define TPG_OFS_C_LEVEL 16'h7f9b
`define TPG_OFS_A_DIR 16'h7f9c
`define TPG_OFS_B_DIR 16'h7f9d
`define TPG_OFS_C_DIR 16'h7f9e

// field layout and reset values
`define TPG_PORT_W 8
`define TPG_RST_DRIVE 8'h00
`define TPG_RST_DIR 8'h00
`define TPG_RD_IDLE 8'h00

`endif

// File: include/tpg_pkg.sv
// shared types of the three-port gpio block
// assumes nothing beyond a systemverilog compiler
package tpg_pkg;

  // one port's worth of bits
  typedef logic [7:0] tpg_byte_t;

  // decoded register selected by the bus address
  typedef enum logic [3:0] {
    TPG_SEL_NONE = 4'h0,
    TPG_SEL_A_DRIVE = 4'h1,
    TPG_SEL_B_DRIVE = 4'h2,
    TPG_SEL_C_DRIVE = 4'h3,
    TPG_SEL_A_LEVEL = 4'h4,
    TPG_SEL_B_LEVEL = 4'h5,
    TPG_SEL_C_LEVEL = 4'h6,
    TPG_SEL_A_DIR = 4'h7,
    TPG_SEL_B_DIR = 4'h8,
    TPG_SEL_C_DIR = 4'h9
  } tpg_sel_t;

endpackage

// File: hw/tpg_port.sv
// one gpio port: pin synchroniser and per-bit tri-state gating
// assumes drive and direction bits come from flops on clk, alt select
// from configuration logic on clk, pins from outside the clock domain
`timescale 1ns/1ps
module tpg_port #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register file state and the alternate select
  input wire logic [WIDTH-1:0] drive_latch,
  input wire logic [WIDTH-1:0] drive_dir,
  input wire logic [WIDTH-1:0] alt_function_select,
  // pin side
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  // synchronised pin level
  output logic [WIDTH-1:0] pin_level_sample
);

  // refuse widths that the byte-wide registers cannot carry
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("tpg_port width must be 1 to 8");
  end

  logic [WIDTH-1:0] meta_q; // first stage, read only by the second
  logic [WIDTH-1:0] sync_q; // second stage, safe to use

  // two-stage synchroniser, taken whatever drives the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q; // R3
    end
  end

  assign pin_level_sample = sync_q;

  // per-bit driver gating
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // latch value always presented; only the enable decides if it reaches the pad
    assign pin_out[i] = drive_latch[i]; // R2
    // driver on only for plain i/o with direction set
    assign pin_oe[i] = drive_dir[i] & ~alt_function_select[i]; // R1 R4 R5 R6
  end

endmodule

// File: hw/tpg_top.sv
// Operation
// R1 - drive pin when enabled and not alternate
// R2 - latch stores writes even when undriven
// R3 - level register reads actual pin level
// R4 - enable bit one makes pin output
// R5 - alternate select blocks general output drive
// R6 - select zero plain i/o, one alternate
// R7 - writes update state next clock edge
//
// three 8-bit gpio ports behind a byte-wide register port
// assumes a same-clock bus master with one-cycle strobes and
// alternate-function selects supplied by configuration logic on clk
`timescale 1ns/1ps
`include "tpg_params.svh"
module tpg_top #(
  parameter int PORT_W = `TPG_PORT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [`TPG_ADDR_W-1:0] addr,
  input wire logic [PORT_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [PORT_W-1:0] rd_data,
  // alternate-function selects per pin
  input wire logic [PORT_W-1:0] alt_function_select_a,
  input wire logic [PORT_W-1:0] alt_function_select_b,
  input wire logic [PORT_W-1:0] alt_function_select_c,
  // port a pins
  input wire logic [PORT_W-1:0] pin_a_in,
  output logic [PORT_W-1:0] pin_a_out,
  output logic [PORT_W-1:0] pin_a_oe,
  // port b pins
  input wire logic [PORT_W-1:0] pin_b_in,
  output logic [PORT_W-1:0] pin_b_out,
  output logic [PORT_W-1:0] pin_b_oe,
  // port c pins
  input wire logic [PORT_W-1:0] pin_c_in,
  output logic [PORT_W-1:0] pin_c_out,
  output logic [PORT_W-1:0] pin_c_oe
);

  // registers are a byte wide, so the port width is fixed
  if (PORT_W != 8) begin : g_bad_port_w
    $error("tpg_top port width must be 8");
  end

  tpg_pkg::tpg_sel_t sel; // decoded address
  logic [PORT_W-1:0] drv_a_q; // port a drive latch
  logic [PORT_W-1:0] drv_b_q; // port b drive latch
  logic [PORT_W-1:0] drv_c_q; // port c drive latch
  logic [PORT_W-1:0] dir_a_q; // port a direction
  logic [PORT_W-1:0] dir_b_q; // port b direction
  logic [PORT_W-1:0] dir_c_q; // port c direction
  logic [PORT_W-1:0] lvl_a; // synchronised pin levels
  logic [PORT_W-1:0] lvl_b;
  logic [PORT_W-1:0] lvl_c;
  logic [PORT_W-1:0] rd_data_d; // read mux
  logic [PORT_W-1:0] rd_data_q; // read data, one cycle after strobe

  // address decode, full 16-bit match
  always_comb begin
    case (addr)
      `TPG_OFS_A_DRIVE: sel = tpg_pkg::TPG_SEL_A_DRIVE;
      `TPG_OFS_B_DRIVE: sel = tpg_pkg::TPG_SEL_B_DRIVE;
      `TPG_OFS_C_DRIVE: sel = tpg_pkg::TPG_SEL_C_DRIVE;
      `TPG_OFS_A_LEVEL: sel = tpg_pkg::TPG_SEL_A_LEVEL;
      `TPG_OFS_B_LEVEL: sel = tpg_pkg::TPG_SEL_B_LEVEL;
      `TPG_OFS_C_LEVEL: sel = tpg_pkg::TPG_SEL_C_LEVEL;
      `TPG_OFS_A_DIR: sel = tpg_pkg::TPG_SEL_A_DIR;
      `TPG_OFS_B_DIR: sel = tpg_pkg::TPG_SEL_B_DIR;
      `TPG_OFS_C_DIR: sel = tpg_pkg::TPG_SEL_C_DIR;
      default: sel = tpg_pkg::TPG_SEL_NONE; // unmapped
    endcase
  end

  // drive latches; stored regardless of direction so software can
  // preload a level before turning the driver on without a glitch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_a_q <= `TPG_RST_DRIVE;
      drv_b_q <= `TPG_RST_DRIVE;
      drv_c_q <= `TPG_RST_DRIVE;
    end else if (wr_en) begin
      case (sel)
        tpg_pkg::TPG_SEL_A_DRIVE: drv_a_q <= wr_data; // R2 R7
        tpg_pkg::TPG_SEL_B_DRIVE: drv_b_q <= wr_data; // R2 R7
        tpg_pkg::TPG_SEL_C_DRIVE: drv_c_q <= wr_data; // R2 R7
        default: ; // level registers are read only
      endcase
    end
  end

  // direction registers; reset to input so nothing fights the board
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_a_q <= `TPG_RST_DIR;
      dir_b_q <= `TPG_RST_DIR;
      dir_c_q <= `TPG_RST_DIR;
    end else if (wr_en) begin
      case (sel)
        tpg_pkg::TPG_SEL_A_DIR: dir_a_q <= wr_data; // R4 R7
        tpg_pkg::TPG_SEL_B_DIR: dir_b_q <= wr_data; // R4 R7
        tpg_pkg::TPG_SEL_C_DIR: dir_c_q <= wr_data; // R4 R7
        default: ; // other offsets ignored
      endcase
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    case (sel)
      tpg_pkg::TPG_SEL_A_DRIVE: rd_data_d = drv_a_q;
      tpg_pkg::TPG_SEL_B_DRIVE: rd_data_d = drv_b_q;
      tpg_pkg::TPG_SEL_C_DRIVE: rd_data_d = drv_c_q;
      tpg_pkg::TPG_SEL_A_LEVEL: rd_data_d = lvl_a; // R3
      tpg_pkg::TPG_SEL_B_LEVEL: rd_data_d = lvl_b; // R3
      tpg_pkg::TPG_SEL_C_LEVEL: rd_data_d = lvl_c; // R3
      tpg_pkg::TPG_SEL_A_DIR: rd_data_d = dir_a_q;
      tpg_pkg::TPG_SEL_B_DIR: rd_data_d = dir_b_q;
      tpg_pkg::TPG_SEL_C_DIR: rd_data_d = dir_c_q;
      default: rd_data_d = `TPG_RD_IDLE;
    endcase
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= `TPG_RD_IDLE;
    end else if (rd_en) begin
      rd_data_q <= rd_data_d;
    end else begin
      rd_data_q <= `TPG_RD_IDLE;
    end
  end

  assign rd_data = rd_data_q;

  // port a
  tpg_port #(.WIDTH(PORT_W)) u_port_a (
    .clk(clk),
    .rst_n(rst_n),
    .drive_latch(drv_a_q),
    .drive_dir(dir_a_q),
    .alt_function_select(alt_function_select_a),
    .pin_in(pin_a_in),
    .pin_out(pin_a_out),
    .pin_oe(pin_a_oe),
    .pin_level_sample(lvl_a)
  );

  // port b
  tpg_port #(.WIDTH(PORT_W)) u_port_b (
    .clk(clk),
    .rst_n(rst_n),
    .drive_latch(drv_b_q),
    .drive_dir(dir_b_q),
    .alt_function_select(alt_function_select_b),
    .pin_in(pin_b_in),
    .pin_out(pin_b_out),
    .pin_oe(pin_b_oe),
    .pin_level_sample(lvl_b)
  );

  // port c
  tpg_port #(.WIDTH(PORT_W)) u_port_c (
    .clk(clk),
    .rst_n(rst_n),
    .drive_latch(drv_c_q),
    .drive_dir(dir_c_q),
    .alt_function_select(alt_function_select_c),
    .pin_in(pin_c_in),
    .pin_out(pin_c_out),
    .pin_oe(pin_c_oe),
    .pin_level_sample(lvl_c)
  );

  // checks on the pin gating and the register port
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // a driven pin must have its direction bit set
  a_drive_needs_dir: assert property ( // R1
    ((pin_a_oe & ~dir_a_q) | (pin_b_oe & ~dir_b_q) | (pin_c_oe & ~dir_c_q)) == '0)
    else $error("pin driven without direction bit");

  // latch write lands on the pin value next cycle even with driver off
  a_latch_store: assert property ( // R2
    (wr_en && addr == `TPG_OFS_A_DRIVE && dir_a_q == '0)
      |=> (pin_a_out == $past(wr_data) && pin_a_oe == '0))
    else $error("port a latch not stored while undriven");

  // level read returns the synchronised pin value at the strobe
  a_level_read: assert property ( // R3
    (rd_en && addr == `TPG_OFS_B_LEVEL) |=> (rd_data == $past(lvl_b)))
    else $error("port b level read mismatch");

  // pin level follows the pad two edges later
  a_level_sync: assert property ( // R3
    ##2 (lvl_c == $past(pin_c_in, 2)))
    else $error("port c level not two cycles behind pin");

  // direction write with plain i/o selected turns drivers on next cycle
  a_dir_enable: assert property ( // R4
    (wr_en && addr == `TPG_OFS_C_DIR && alt_function_select_c == '0 ##1 alt_function_select_c == '0)
      |-> (pin_c_oe == $past(wr_data)))
    else $error("port c direction write not reflected");

  // alternate select keeps general output off
  a_alt_blocks: assert property ( // R5
    ((pin_a_oe & alt_function_select_a) | (pin_b_oe & alt_function_select_b)
      | (pin_c_oe & alt_function_select_c)) == '0)
    else $error("pin driven while alternate function selected");

  // plain i/o with direction set must drive
  a_plain_io: assert property ( // R6
    ((dir_b_q & ~alt_function_select_b) & ~pin_b_oe) == '0)
    else $error("port b plain i/o pin not driven");

  // written direction reads back on the following read
  a_write_readback: assert property ( // R7
    (wr_en && addr == `TPG_OFS_A_DIR ##1 rd_en && addr == `TPG_OFS_A_DIR)
      |=> (rd_data == $past(wr_data, 2)))
    else $error("port a direction readback mismatch");

  // read data is zero outside the cycle after a read
  a_rd_idle: assert property (
    !rd_en |=> (rd_data == '0))
    else $error("read data not idle");

endmodule

// File: testbench/tpg_board_model.sv
// board-side model of the circuitry on one gpio port
// assumes the device gives out/oe per pin and the board holds ext
`timescale 1ns/1ps
module tpg_board_model (
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // value the board puts on the pin when the device lets go
  input wire logic [7:0] ext,
  // resolved pad level
  output logic [7:0] pad
);
  // per-bit resolution; the board is weaker than the device driver
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// File: testbench/tpg_top_tb_top.sv
// self-checking bench for the three-port gpio register block
// assumes one 125 mhz clock and boards that yield to the device
`timescale 1ns/1ps
`include "tpg_params.svh"
module tpg_top_tb_top;
  // clock, reset and register port
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_seen = 1'b0; // a read was taken last edge
  logic [7:0] rd_data;
  // per-port pin side, index 0..2 is port a..c
  logic [7:0] alt [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] pout [3];
  logic [7:0] poe [3];
  logic [7:0] pad [3];
  // expected read data, oldest first
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h5af4_82a4;
  tpg_pkg::tpg_byte_t dv, dr, al, ex, lv;

  // free-running clock, 8 ns period
  always #4 clk = ~clk;

  tpg_top i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .alt_function_select_a(alt[0]),
    .alt_function_select_b(alt[1]), .alt_function_select_c(alt[2]),
    .pin_a_in(pad[0]), .pin_a_out(pout[0]), .pin_a_oe(poe[0]),
    .pin_b_in(pad[1]), .pin_b_out(pout[1]), .pin_b_oe(poe[1]),
    .pin_c_in(pad[2]), .pin_c_out(pout[2]), .pin_c_oe(poe[2])
  );

  // one board per port
  for (genvar i = 0; i < 3; i++) begin : g_board
    tpg_board_model i_board (.pin_out(pout[i]), .pin_oe(poe[i]), .ext(ext[i]), .pad(pad[i]));
  end

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single-cycle write; the idle edge after it avoids double drives
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // write then read of the same place with no gap; the strobes hand over
  // at the taking edge of the write, so no signal is assigned twice
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    exp_q.push_back(d);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // single-cycle read; the expectation is queued for the monitor
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_seen <= rd_en;
  always @(negedge clk) begin
    if (rd_seen) begin
      chk(rd_data, exp_q.pop_front());
    end
  end

  // verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values of all nine registers, then unmapped places
    for (int r = 0; r < 9; r++) begin
      rd(16'(`TPG_OFS_A_DRIVE + r), 8'h00);
    end
    rd(16'h7f9f, 8'h00);
    rd(16'h0000, 8'h00);
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 4; k++) begin
        dv = 8'($random(seed));
        dr = 8'($random(seed));
        al = 8'($random(seed));
        ex = 8'($random(seed));
        // first pass per port is plain i/o up to the select flip, so the
        // direction write must turn every set driver on
        if (k == 0) begin
          al = 8'h00;
        end
        @(posedge clk);
        alt[p] <= al;
        ext[p] <= ex;
        wr(16'(`TPG_OFS_A_DRIVE + p), dv);
        wr_rd(16'(`TPG_OFS_A_DIR + p), dr);
        // new state shows right after the taking edge
        @(negedge clk);
        chk(pout[p], dv);
        chk(poe[p], dr & ~al);
        rd(16'(`TPG_OFS_A_DRIVE + p), dv);
        rd(16'(`TPG_OFS_A_DIR + p), dr);
        lv = (dr & ~al & dv) | (~(dr & ~al) & ex);
        // level register is read-only; the write must leave no trace
        wr(16'(`TPG_OFS_A_LEVEL + p), ~lv);
        rd(16'(`TPG_OFS_A_LEVEL + p), lv);
        // flipping the selects alone moves the enables at once
        @(posedge clk);
        alt[p] <= ~al;
        @(negedge clk);
        chk(poe[p], dr & al);
      end
    end
    repeat (2) @(posedge clk);
    tally_and_finish();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #(8 * 5000);
    error_cnt++;
    tally_and_finish();
  end
endmodule
